// ==== brs_assertions.sv ====
// Assertions on the link between the two sequencer ends
`timescale 1ns/1ns
`default_nettype none
module brs_assertions #(
  parameter int GRANT_CYC = 20
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic ext_reset_in_n,
  input wire logic full_reset_strobe,
  input wire logic local_bus_request_n,
  input wire logic local_bus_grant_n,
  input wire logic halt_n,
  input wire logic local_reset_n,
  input wire logic outputs_hiz,
  input wire logic sysreset_in_n,
  input wire logic sysreset_out_n,
  input wire logic sysreset_oe,
  input wire logic sysfail_n,
  input wire logic sysclk_en,
  input wire logic bg_chain_en
);
  localparam int TMO = GRANT_CYC + 4;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  req_on_ext_a: assert property ($fell(ext_reset_in_n) && halt_n && local_bus_request_n
    |-> ##[1:4] !local_bus_request_n) else $error("bus request missing after external reset");
  halt_on_grant_a: assert property (!local_bus_request_n && !local_bus_grant_n |-> ##[0:4] !halt_n)
    else $error("halt missing after grant");
  grant_tmo_a: assert property ($fell(local_bus_request_n) |-> ##[1:TMO] !halt_n)
    else $error("halt missing after grant timeout");
  req_drop_a: assert property ($fell(halt_n) |-> ##[0:1] (local_bus_request_n && outputs_hiz))
    else $error("request kept or outputs driven during halt");
  hold_ext_a: assert property (!halt_n && !ext_reset_in_n |=> !halt_n)
    else $error("halt released while external reset held");
  strobe_cut_a: assert property (full_reset_strobe [*4] |-> !sysclk_en && !bg_chain_en)
    else $error("clock or grant chain active during strobe");
  sysreset_drv_a: assert property (sysreset_oe |-> !sysreset_out_n && !halt_n)
    else $error("backplane reset driven outside local reset");
  release_idle_a: assert property ($rose(halt_n) |-> ##[0:1] (local_reset_n && !outputs_hiz && !sysreset_oe))
    else $error("outputs not idle after reset end");
endmodule
`default_nettype wire

// ==== brs_dev.sv ====
// Device end: reset sequencer with its register port
`timescale 1ns/1ns
`default_nettype none
module brs_dev #(
  parameter int unsigned GRANT_CYC = brs_pkg::GRANT_TMO_CYC,
  parameter int unsigned HOLD_CYC = brs_pkg::HOLD_CYC
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  brs_if.dev link,
  input wire logic [1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o
);
  typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_HOLD} brs_st_t;
  brs_st_t st_q;
  logic [1:0] s_ext_q, s_stb_q, s_sys_q, s_gnt_q;
  logic ext_a, stb_a, sys_a, gnt_a;
  logic start, enter_hold;
  logic [23:0] cnt_q;
  brs_pkg::brs_src_t src_q;
  logic fail_q, rel_q, syscon_q, busy_q, glb_seen_q;
  logic sw_trig_q, drive_sys_q;
  logic req_n_q, halt_n_q, rst_n_q, hiz_q, sysrst_n_q, sysrst_oe_q;
  logic sysclk_en_q, bg_en_q, sysfail_n_q;
  logic [7:0] rdata_q;
  logic done;

  always_ff @(posedge sys_clk_i) begin
    s_ext_q <= {s_ext_q[0], ~link.ext_reset_in_n};
    s_stb_q <= {s_stb_q[0], link.full_reset_strobe};
    s_sys_q <= {s_sys_q[0], ~link.sysreset_in_n};
    s_gnt_q <= {s_gnt_q[0], ~link.local_bus_grant_n};
  end
  assign ext_a = s_ext_q[1];
  assign stb_a = s_stb_q[1] & ext_a;
  assign sys_a = s_sys_q[1] & ~drive_sys_q;
  assign gnt_a = s_gnt_q[1];
  assign start = ext_a || sys_a || sw_trig_q;
  assign enter_hold = st_q == ST_REQ && (gnt_a || cnt_q == 24'h0);

  // End of hold: internal after timer with input gone, global at reset release while strobe stands, system after timer with input released
  always_comb begin
    done = 1'b0;
    if (st_q == ST_HOLD) begin
      if (src_q == brs_pkg::BRS_SRC_GLB && glb_seen_q && !ext_a && s_stb_q[1])
        done = 1'b1;
      else if (src_q == brs_pkg::BRS_SRC_SYS && cnt_q == 24'h0 && !sys_a)
        done = 1'b1;
      else if (cnt_q == 24'h0 && !ext_a && !sys_a && !sw_trig_q && !stb_a)
        done = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      st_q <= ST_IDLE;
      cnt_q <= 24'h0;
      src_q <= brs_pkg::BRS_SRC_NONE;
    end else begin
      // Highest active source recorded
      if (stb_a) src_q <= brs_pkg::BRS_SRC_GLB;
      else if (ext_a && src_q != brs_pkg::BRS_SRC_GLB) src_q <= brs_pkg::BRS_SRC_INT;
      else if ((sys_a || sw_trig_q) && src_q == brs_pkg::BRS_SRC_NONE) src_q <= brs_pkg::BRS_SRC_SYS;
      case (st_q)
        ST_IDLE: begin
          if (ext_a || sys_a || sw_trig_q) begin
            st_q <= ST_REQ;
            cnt_q <= 24'(GRANT_CYC - 1);
          end
        end
        ST_REQ: begin
          if (gnt_a || cnt_q == 24'h0) begin
            st_q <= ST_HOLD;
            cnt_q <= 24'(HOLD_CYC - 1);
          end else cnt_q <= cnt_q - 24'h1;
        end
        ST_HOLD: begin
          if (done) begin
            st_q <= ST_IDLE;
            src_q <= brs_pkg::BRS_SRC_NONE;
          end else if (ext_a || stb_a || (cnt_q == 24'h0 && src_q != brs_pkg::BRS_SRC_SYS)) begin
            cnt_q <= 24'(HOLD_CYC - 1);
          end else if (cnt_q != 24'h0) begin
            cnt_q <= cnt_q - 24'h1;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) glb_seen_q <= 1'b0;
    else if (stb_a) glb_seen_q <= 1'b1;
    else if (st_q == ST_IDLE) glb_seen_q <= 1'b0;
  end

  // Local bus request, raised on a new source, dropped with halt
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      req_n_q <= 1'b1;
    end else begin
      req_n_q <= ~((st_q == ST_IDLE && start) || (st_q == ST_REQ && !enter_hold));
    end
  end

  // Local halt, held through the whole hold phase
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      halt_n_q <= 1'b1;
    end else begin
      halt_n_q <= ~(enter_hold || (st_q == ST_HOLD && !done));
    end
  end

  // Local reset, its own register so the pin comes from a flop
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      rst_n_q <= 1'b1;
    end else begin
      rst_n_q <= ~(enter_hold || (st_q == ST_HOLD && !done));
    end
  end

  // Three-state outputs released while the local side is halted
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      hiz_q <= 1'b0;
    end else begin
      hiz_q <= enter_hold || (st_q == ST_HOLD && !done);
    end
  end

  // Own backplane drive, decided while the local bus is requested
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      drive_sys_q <= 1'b0;
    end else if (st_q == ST_IDLE || done) begin
      drive_sys_q <= 1'b0;
    end else if (st_q == ST_REQ && !s_sys_q[1] &&
                 ((syscon_q && src_q != brs_pkg::BRS_SRC_SYS) || sw_trig_q)) begin
      drive_sys_q <= 1'b1;
    end
  end

  // Backplane reset pin and its enable, only while local halt stands
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      sysrst_n_q <= 1'b1;
      sysrst_oe_q <= 1'b0;
    end else begin
      sysrst_n_q <= ~(drive_sys_q && !halt_n_q && !done);
      sysrst_oe_q <= drive_sys_q && !halt_n_q && !done;
    end
  end

  // Busy status for software
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= st_q != ST_IDLE;
    end
  end

  // Strobe stops the system clock and cuts the grant chain
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      sysclk_en_q <= 1'b1;
      bg_en_q <= 1'b1;
    end else begin
      sysclk_en_q <= ~stb_a;
      bg_en_q <= ~stb_a;
    end
  end

  // Failure line follows the flag unless software released it
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      sysfail_n_q <= 1'b1;
    end else begin
      sysfail_n_q <= ~(fail_q & ~rel_q);
    end
  end

  // Register fields: global clears all, other resets a subset
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || stb_a) begin
      rel_q <= 1'b0;
      syscon_q <= brs_pkg::CTRL_RESET[brs_pkg::CTRL_SYSCON_BIT];
      sw_trig_q <= 1'b0;
      fail_q <= 1'b0;
    end else begin
      if (reg_wr_i && reg_addr_i == brs_pkg::ADDR_CTRL) begin
        rel_q <= reg_wdata_i[brs_pkg::CTRL_RELEASE_BIT];
        syscon_q <= reg_wdata_i[brs_pkg::CTRL_SYSCON_BIT];
      end
      if (reg_wr_i && reg_addr_i == brs_pkg::ADDR_SRR && reg_wdata_i == brs_pkg::SRR_TRIGGER)
        sw_trig_q <= 1'b1;
      else if (st_q == ST_HOLD) sw_trig_q <= 1'b0;
      if (done) fail_q <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) rdata_q <= 8'h00;
    else if (reg_rd_i) begin
      case (reg_addr_i)
        brs_pkg::ADDR_CTRL: rdata_q <= {6'h00, syscon_q, rel_q};
        brs_pkg::ADDR_STAT: rdata_q <= {6'h00, busy_q, fail_q};
        brs_pkg::ADDR_SRR: rdata_q <= brs_pkg::SRR_RESET;
        default: rdata_q <= 8'h00;
      endcase
    end else rdata_q <= 8'h00;
  end

  assign reg_rdata_o = rdata_q;
  assign link.local_bus_request_n = req_n_q;
  assign link.halt_n = halt_n_q;
  assign link.local_reset_n = rst_n_q;
  assign link.outputs_hiz = hiz_q;
  assign link.sysreset_out_n = sysrst_n_q;
  assign link.sysreset_oe = sysrst_oe_q;
  assign link.sysfail_n = sysfail_n_q;
  assign link.sysclk_en = sysclk_en_q;
  assign link.bg_chain_en = bg_en_q;
endmodule
`default_nettype wire

// ==== brs_host.sv ====
// Outside party: drives reset pins and answers bus requests
`timescale 1ns/1ns
`default_nettype none
module brs_host (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  brs_if.host link,
  input wire logic push_reset_i,
  input wire logic global_i,
  input wire logic grant_en_i,
  input wire logic bp_reset_i,
  output logic busy_o
);
  typedef enum logic [1:0] {H_IDLE, H_EXT, H_STB, H_HOLD} brs_hst_t;
  brs_hst_t st_q;
  logic [1:0] s_req_q;
  logic ext_q, stb_q, gnt_q, bp_q, busy_q, glb_q;
  logic [23:0] cnt_q;

  always_ff @(posedge sys_clk_i) s_req_q <= {s_req_q[0], ~link.local_bus_request_n};

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      st_q <= H_EXT;
      glb_q <= 1'b1;
      ext_q <= 1'b0;
      stb_q <= 1'b0;
      cnt_q <= 24'h0;
      busy_q <= 1'b1;
    end else begin
      case (st_q)
        H_IDLE: begin
          busy_q <= 1'b0;
          if (push_reset_i) begin
            st_q <= H_EXT;
            glb_q <= global_i;
            busy_q <= 1'b1;
          end
        end
        H_EXT: begin
          ext_q <= 1'b1;
          st_q <= glb_q ? H_STB : H_HOLD;
          cnt_q <= 24'(brs_pkg::HOST_STB_CYC);
        end
        H_STB: begin
          stb_q <= 1'b1;
          if (cnt_q == 24'h0) st_q <= H_HOLD;
          else cnt_q <= cnt_q - 24'h1;
        end
        H_HOLD: begin
          // External reset goes first, strobe one cycle later
          ext_q <= 1'b0;
          if (!ext_q) begin
            stb_q <= 1'b0;
            st_q <= H_IDLE;
          end
        end
        default: st_q <= H_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      gnt_q <= 1'b0;
      bp_q <= 1'b0;
    end else begin
      gnt_q <= grant_en_i & s_req_q[1];
      bp_q <= bp_reset_i;
    end
  end

  assign link.ext_reset_in_n = ~ext_q;
  assign link.full_reset_strobe = stb_q;
  assign link.local_bus_grant_n = ~gnt_q;
  assign link.sysreset_in_n = ~bp_q;
  assign busy_o = busy_q;
endmodule
`default_nettype wire

// ==== brs_if.sv ====
// Interface joining sequencer and its outside party
`timescale 1ns/1ns
`default_nettype none
interface brs_if;
  logic ext_reset_in_n;
  logic full_reset_strobe;
  logic local_bus_request_n;
  logic local_bus_grant_n;
  logic halt_n;
  logic local_reset_n;
  logic outputs_hiz;
  logic sysreset_in_n;
  logic sysreset_out_n;
  logic sysreset_oe;
  logic sysfail_n;
  logic sysclk_en;
  logic bg_chain_en;
  modport dev (
    input ext_reset_in_n, full_reset_strobe, local_bus_grant_n, sysreset_in_n,
    output local_bus_request_n, halt_n, local_reset_n, outputs_hiz, sysreset_out_n,
    output sysreset_oe, sysfail_n, sysclk_en, bg_chain_en
  );
  modport host (
    output ext_reset_in_n, full_reset_strobe, local_bus_grant_n, sysreset_in_n,
    input local_bus_request_n, halt_n, local_reset_n, outputs_hiz, sysreset_out_n,
    input sysreset_oe, sysfail_n, sysclk_en, bg_chain_en
  );
endinterface
`default_nettype wire

// ==== brs_pkg.sv ====
// Package for the bus interface reset sequencer
// Functional notes
// - Priority: global, then internal, then system
// - Reset completion sets system-failure flag
// - Release bit clears failure; global clears it
// - External reset held at least 20 ns
// - External reset raises local bus request
// - Wait for grant, timeout then halt/reset
// - On halt: drop request, tristate, start timer
// - Timer restarts while external reset held
// - System controller drives backplane reset too
// - Conclusion releases resets, outputs go idle
// - Global resets all fields; others subset
// - Strobe follows external reset by 16/20 ns
// - Strobe held at least 50 ns
// - Strobe stops clock and breaks grant chain
// - Before strobe internal; after, global defaults
// - Strobe first: timer; reset first: end now
// - Writing f0 to reset register resets system
// - Backplane reset runs internal sequence
// - Long backplane reset ends at its release
// - Never drive backplane reset driven by others
// - Global reset required at power-up
package brs_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned GRANT_TMO_US = 1000;
  localparam int unsigned GRANT_TMO_CYC = GRANT_TMO_US * (CLK_HZ / 1_000_000);
  localparam int unsigned HOLD_MS = 200;
  localparam int unsigned HOLD_CYC = HOLD_MS * (CLK_HZ / 1000);
  localparam int unsigned HOST_STB_CYC = 32;
  localparam logic [1:0] ADDR_CTRL = 2'h0;
  localparam logic [1:0] ADDR_STAT = 2'h1;
  localparam logic [1:0] ADDR_SRR = 2'h2;
  localparam logic [7:0] SRR_TRIGGER = 8'hf0;
  localparam logic [7:0] SRR_RESET = 8'hff;
  localparam int unsigned CTRL_RELEASE_BIT = 0;
  localparam int unsigned CTRL_SYSCON_BIT = 1;
  localparam int unsigned STAT_FAIL_BIT = 0;
  localparam int unsigned STAT_BUSY_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  typedef enum logic [1:0] {
    BRS_SRC_NONE,
    BRS_SRC_SYS,
    BRS_SRC_INT,
    BRS_SRC_GLB
  } brs_src_t;
endpackage

// ==== bus_interface_reset_sequencer_tb.sv ====
// Testbench joining both sequencer ends through the link
`timescale 1ns/1ns
`default_nettype none
module bus_interface_reset_sequencer_tb;
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic push = 1'b0;
  logic glb = 1'b0;
  logic gnt = 1'b1;
  logic bp = 1'b0;
  int fails = 0;
  int n_checks = 0;
  brs_if link ();
  brs_dev #(.GRANT_CYC(20), .HOLD_CYC(50)) i_brs_dev (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .link(link),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata));
  brs_host i_brs_host (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .link(link), .push_reset_i(push),
    .global_i(glb), .grant_en_i(gnt), .bp_reset_i(bp), .busy_o());
  brs_assertions #(.GRANT_CYC(20)) i_brs_assertions (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .ext_reset_in_n(link.ext_reset_in_n), .full_reset_strobe(link.full_reset_strobe),
    .local_bus_request_n(link.local_bus_request_n), .local_bus_grant_n(link.local_bus_grant_n),
    .halt_n(link.halt_n), .local_reset_n(link.local_reset_n), .outputs_hiz(link.outputs_hiz),
    .sysreset_in_n(link.sysreset_in_n), .sysreset_out_n(link.sysreset_out_n), .sysreset_oe(link.sysreset_oe),
    .sysfail_n(link.sysfail_n), .sysclk_en(link.sysclk_en), .bg_chain_en(link.bg_chain_en));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk_i);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp);
    @(posedge sys_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk_i);
    rd <= 1'b0;
    @(negedge sys_clk_i);
    chk(rdata, exp);
  endtask
  task automatic wait_halt(input logic lvl, input int lim);
    int i;
    for (i = 0; i < lim && link.halt_n !== lvl; i++) @(negedge sys_clk_i);
    chk({7'h00, link.halt_n}, {7'h00, lvl});
  endtask
  task automatic pulse(input logic g, input logic en);
    @(posedge sys_clk_i);
    glb <= g;
    gnt <= en;
    push <= 1'b1;
    @(posedge sys_clk_i);
    push <= 1'b0;
  endtask
  task automatic t_power();
    wait_halt(1'b0, 200);
    wait_halt(1'b1, 400);
    rd_chk(brs_pkg::ADDR_STAT, 8'h01);
    chk({7'h00, link.sysfail_n}, 8'h00);
    rd_chk(brs_pkg::ADDR_CTRL, 8'h00);
    rd_chk(2'h3, 8'h00);
    $display("power-up test done");
  endtask
  task automatic t_int();
    int n;
    wr_reg(brs_pkg::ADDR_CTRL, 8'h01);
    repeat (2) @(negedge sys_clk_i);
    chk({7'h00, link.sysfail_n}, 8'h01);
    pulse(1'b0, 1'b0);
    for (n = 0; n < 10 && link.local_bus_request_n !== 1'b0; n++) @(negedge sys_clk_i);
    chk({7'h00, link.local_bus_request_n}, 8'h00);
    for (n = 0; n < 100 && link.halt_n !== 1'b0; n++) @(negedge sys_clk_i);
    chk({7'h00, n >= 18 && n < 100}, 8'h01);
    wait_halt(1'b1, 400);
    rd_chk(brs_pkg::ADDR_CTRL, 8'h01);
    $display("internal reset test done");
  endtask
  task automatic t_srr();
    wr_reg(brs_pkg::ADDR_SRR, 8'h55);
    repeat (10) @(negedge sys_clk_i);
    chk({7'h00, link.halt_n}, 8'h01);
    rd_chk(brs_pkg::ADDR_SRR, 8'hff);
    wr_reg(brs_pkg::ADDR_SRR, 8'hf0);
    wait_halt(1'b0, 60);
    wait_halt(1'b1, 400);
    $display("system reset register test done");
  endtask
  task automatic t_glb();
    pulse(1'b1, 1'b1);
    wait_halt(1'b0, 60);
    wait_halt(1'b1, 40);
    rd_chk(brs_pkg::ADDR_CTRL, 8'h00);
    @(posedge sys_clk_i);
    glb <= 1'b0;
    $display("global reset test done");
  endtask
  task automatic t_syscon();
    wr_reg(brs_pkg::ADDR_CTRL, 8'h02);
    pulse(1'b0, 1'b1);
    wait_halt(1'b0, 60);
    @(negedge sys_clk_i);
    chk({7'h00, link.sysreset_oe}, 8'h01);
    chk({7'h00, link.sysreset_out_n}, 8'h00);
    wait_halt(1'b1, 400);
    @(negedge sys_clk_i);
    chk({7'h00, link.sysreset_oe}, 8'h00);
    pulse(1'b0, 1'b1);
    bp <= 1'b1;
    wait_halt(1'b0, 60);
    @(negedge sys_clk_i);
    chk({7'h00, link.sysreset_oe}, 8'h00);
    @(posedge sys_clk_i);
    bp <= 1'b0;
    wait_halt(1'b1, 400);
    $display("system controller test done");
  endtask
  task automatic t_bp();
    @(posedge sys_clk_i);
    bp <= 1'b1;
    wait_halt(1'b0, 60);
    repeat (80) @(negedge sys_clk_i);
    chk({7'h00, link.halt_n}, 8'h00);
    @(posedge sys_clk_i);
    bp <= 1'b0;
    wait_halt(1'b1, 10);
    $display("backplane reset test done");
  endtask
  initial begin
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    repeat (5) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    t_power();
    t_int();
    t_srr();
    t_glb();
    t_syscon();
    t_bp();
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    fails++;
    end_sim();
  end
endmodule
`default_nettype wire
